// File: rtl/irf_pkg.sv
// Package for the interrupt request flag block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
package irf_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_EXT_FLAGS = 6'h00;
  localparam logic [5:0] OFS_DMA_SER = 6'h04;
  localparam logic [5:0] OFS_CONV_SER = 6'h08;
  localparam logic [5:0] OFS_EXT_SENSE = 6'h0C;
  localparam logic [5:0] OFS_PORT_SENSE = 6'h10;
  localparam logic [5:0] OFS_PORT_ENABLE = 6'h14;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [11:0] RST_EXT_SENSE = 12'h000;
  localparam logic [15:0] RST_PORT = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam int BIT_GRP_LOW = 7;
  localparam int BIT_GRP_HIGH = 6;
  localparam int CONV_USED = 5;
  localparam int ST_EXT = 0;
  localparam int ST_DMA = 1;
  localparam int ST_CONV = 2;
  localparam int ST_W = 3;
  typedef enum logic [1:0] {
    IRF_FALLING = 2'b00,
    IRF_RISING = 2'b01,
    IRF_LOW = 2'b10,
    IRF_RSVD = 2'b11
  } irf_sense_e;
endpackage

// File: rtl/irf_ext_line.sv
// One external request line: sense detection and the request flag.
// Assumes the pin input is already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none
module irf_ext_line (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic [1:0] i_sense,
  input wire logic i_clr,
  output logic o_flag
);
  logic pin_d_ff;
  logic flag_ff;
  logic edge_evt;
  logic nxt_flag;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= i_pin;
    end
  end

  always_comb begin
    edge_evt = 1'b0;
    nxt_flag = flag_ff;
    unique case (irf_pkg::irf_sense_e'(i_sense))
      irf_pkg::IRF_FALLING: edge_evt = pin_d_ff & ~i_pin;
      irf_pkg::IRF_RISING: edge_evt = ~pin_d_ff & i_pin;
      irf_pkg::IRF_LOW: edge_evt = 1'b0;
      irf_pkg::IRF_RSVD: edge_evt = 1'b0;
    endcase
    if (irf_pkg::irf_sense_e'(i_sense) == irf_pkg::IRF_LOW) begin
      nxt_flag = ~i_pin;
    end else if (edge_evt) begin
      nxt_flag = 1'b1;
    end else if (i_clr) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;
endmodule
`default_nettype wire

// File: rtl/irf_top.sv
// Interrupt request flag registers with an Avalon-MM slave and summary interrupt.
// Assumes one clock; pins are synchronised here, module requests share the clock.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - External flag register, eight bits, resets zero.
// - Writing one leaves a line flag unchanged.
// - Bit 7 shows any enabled pin 0-7.
// - Bit 6 shows any enabled pin 8-15.
// - Bits 5-0 latch external edge requests; in low-level sense they follow the pin.
// - Clearing an edge flag withdraws the request.
// - Second request register, read-only, resets zero.
// - Bits 7-4: serial A transmit, break, receive, error.
// - Bits 3-0: DMA channel end requests.
// - Third request register, read-only, resets zero.
// - Bit 4: converter completion request.
// - Bits 3-0: serial B requests.
// - Bits 7-5 of third register read zero.
// - Line sense: fall, rise, low, reserved.
// - Port pin sense: low or high level.
// - Disabled port pins never reach summaries.
module irf_top #(
  parameter int N_EXT = 6,
  parameter int N_PORT = 16
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [5:0] I_EXTERNAL_REQUEST_PIN,
  input wire logic [15:0] I_PORT_INTERRUPT_PIN,
  input wire logic [3:0] I_SERIAL_A_REQ,
  input wire logic [3:0] I_DMA_END_REQ,
  input wire logic I_CONVERTER_DONE_REQ,
  input wire logic [3:0] I_SERIAL_B_REQ,
  output logic O_IRQ
);
  if (N_EXT != 6 || N_PORT != 16) begin : g_bad_size
    $error("irf_top supports six lines and sixteen port pins only");
  end

  logic [5:0] ext_s1_ff, ext_s2_ff;
  logic [15:0] port_s1_ff, port_s2_ff;
  logic [11:0] ext_sense_ff;
  logic [15:0] port_sense_ff;
  logic [15:0] port_enable_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic [5:0] ext_flag;
  logic [5:0] ext_clr;
  logic [15:0] port_req;
  logic grp_low_ff, grp_high_ff;
  logic [7:0] dma_ser_ff;
  logic [7:0] conv_ser_ff;
  logic [7:0] ext_reg;
  logic [7:0] ext_reg_d_ff;
  logic [7:0] dma_d_ff;
  logic [7:0] conv_d_ff;
  logic [2:0] evt;
  logic req;
  logic wr_acc, rd_acc;
  logic [31:0] nxt_rdata;

  // Two-stage synchronisers on every asynchronous request input.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_s1_ff <= 6'h3F;
      ext_s2_ff <= 6'h3F;
      port_s1_ff <= 16'h0000;
      port_s2_ff <= 16'h0000;
    end else begin
      ext_s1_ff <= I_EXTERNAL_REQUEST_PIN;
      ext_s2_ff <= ext_s1_ff;
      port_s1_ff <= I_PORT_INTERRUPT_PIN;
      port_s2_ff <= port_s1_ff;
    end
  end

  // Bus handshake: one wait cycle, the answer comes on the second edge.
  assign req = (I_AVS_READ | I_AVS_WRITE) & ~ack_ff;
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_ff;
  assign wr_acc = I_AVS_WRITE & ack_ff;
  assign rd_acc = I_AVS_READ & req;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Flag clear: zero written where the byte is enabled, ones leave bits alone.
  assign ext_clr = (wr_acc && I_AVS_ADDRESS == irf_pkg::OFS_EXT_FLAGS
                    && I_AVS_BYTEENABLE[0]) ? ~I_AVS_WRITEDATA[5:0] : 6'h00;

  genvar g;
  generate
    for (g = 0; g < N_EXT; g++) begin : g_ext
      irf_ext_line u_line (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_pin(ext_s2_ff[g]),
        .i_sense(ext_sense_ff[2*g +: 2]),
        .i_clr(ext_clr[g]),
        .o_flag(ext_flag[g])
      );
    end
  endgenerate

  // Port pins: per-pin level polarity, then enable gating.
  assign port_req = ~(port_s2_ff ^ port_sense_ff) & port_enable_ff;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      grp_low_ff <= 1'b0;
      grp_high_ff <= 1'b0;
    end else begin
      grp_low_ff <= |port_req[7:0];
      grp_high_ff <= |port_req[15:8];
    end
  end

  assign ext_reg = {grp_low_ff, grp_high_ff, ext_flag};

  // Module request flags mirror their same-clock sources one edge later.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dma_ser_ff <= irf_pkg::RST_FLAGS;
      conv_ser_ff <= irf_pkg::RST_FLAGS;
    end else begin
      dma_ser_ff <= {I_SERIAL_A_REQ, I_DMA_END_REQ};
      conv_ser_ff <= {3'b000, I_CONVERTER_DONE_REQ, I_SERIAL_B_REQ};
    end
  end

  // Control registers.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_sense_ff <= irf_pkg::RST_EXT_SENSE;
      port_sense_ff <= irf_pkg::RST_PORT;
      port_enable_ff <= irf_pkg::RST_PORT;
      mask_ff <= 3'b000;
    end else if (wr_acc) begin
      unique case (I_AVS_ADDRESS)
        irf_pkg::OFS_EXT_SENSE: begin
          if (I_AVS_BYTEENABLE[0]) ext_sense_ff[7:0] <= I_AVS_WRITEDATA[7:0];
          if (I_AVS_BYTEENABLE[1]) ext_sense_ff[11:8] <= I_AVS_WRITEDATA[11:8];
        end
        irf_pkg::OFS_PORT_SENSE: begin
          if (I_AVS_BYTEENABLE[0]) port_sense_ff[7:0] <= I_AVS_WRITEDATA[7:0];
          if (I_AVS_BYTEENABLE[1]) port_sense_ff[15:8] <= I_AVS_WRITEDATA[15:8];
        end
        irf_pkg::OFS_PORT_ENABLE: begin
          if (I_AVS_BYTEENABLE[0]) port_enable_ff[7:0] <= I_AVS_WRITEDATA[7:0];
          if (I_AVS_BYTEENABLE[1]) port_enable_ff[15:8] <= I_AVS_WRITEDATA[15:8];
        end
        irf_pkg::OFS_IRQ_MASK: begin
          if (I_AVS_BYTEENABLE[0]) mask_ff <= I_AVS_WRITEDATA[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky status: a rising edge on any bit of a register sets its status bit; set wins over clear.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_reg_d_ff <= irf_pkg::RST_FLAGS;
      dma_d_ff <= irf_pkg::RST_FLAGS;
      conv_d_ff <= irf_pkg::RST_FLAGS;
    end else begin
      ext_reg_d_ff <= ext_reg;
      dma_d_ff <= dma_ser_ff;
      conv_d_ff <= conv_ser_ff;
    end
  end

  assign evt[irf_pkg::ST_EXT] = |(ext_reg & ~ext_reg_d_ff);
  assign evt[irf_pkg::ST_DMA] = |(dma_ser_ff & ~dma_d_ff);
  assign evt[irf_pkg::ST_CONV] = |(conv_ser_ff & ~conv_d_ff);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status_ff <= 3'b000;
    end else if (wr_acc && I_AVS_ADDRESS == irf_pkg::OFS_IRQ_STATUS && I_AVS_BYTEENABLE[0]) begin
      status_ff <= (status_ff & ~I_AVS_WRITEDATA[2:0]) | evt;
    end else begin
      status_ff <= status_ff | evt;
    end
  end

  assign O_IRQ = |(status_ff & mask_ff);

  // Read data, captured in the wait cycle; writes to read-only flags are dropped.
  always_comb begin
    nxt_rdata = irf_pkg::UNMAPPED_READ;
    unique case (I_AVS_ADDRESS)
      irf_pkg::OFS_EXT_FLAGS: nxt_rdata = {24'h000000, ext_reg};
      irf_pkg::OFS_DMA_SER: nxt_rdata = {24'h000000, dma_ser_ff};
      irf_pkg::OFS_CONV_SER: nxt_rdata = {24'h000000, conv_ser_ff};
      irf_pkg::OFS_EXT_SENSE: nxt_rdata = {20'h00000, ext_sense_ff};
      irf_pkg::OFS_PORT_SENSE: nxt_rdata = {16'h0000, port_sense_ff};
      irf_pkg::OFS_PORT_ENABLE: nxt_rdata = {16'h0000, port_enable_ff};
      irf_pkg::OFS_IRQ_STATUS: nxt_rdata = {29'h00000000, status_ff};
      irf_pkg::OFS_IRQ_MASK: nxt_rdata = {29'h00000000, mask_ff};
      default: nxt_rdata = irf_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_ff <= irf_pkg::UNMAPPED_READ;
    end else if (rd_acc) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_AVS_READDATA = rdata_ff;

  property p_grp_low;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> grp_low_ff == ($past(port_req[7:0]) != 8'h00);
  endproperty
  a_grp_low: assert property (p_grp_low) else $error("low group summary wrong");

  property p_grp_high;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> grp_high_ff == ($past(port_req[15:8]) != 8'h00);
  endproperty
  a_grp_high: assert property (p_grp_high) else $error("high group summary wrong");

  property p_grp_low_disabled;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (port_enable_ff[7:0] == 8'h00) [*2] |-> !grp_low_ff;
  endproperty
  a_grp_low_disabled: assert property (p_grp_low_disabled) else $error("disabled low pins seen");

  property p_pin_sense;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      port_enable_ff[0] && port_sense_ff[0] && port_s2_ff[0] |=> grp_low_ff;
  endproperty
  a_pin_sense: assert property (p_pin_sense) else $error("high level not sensed");

  property p_grp_high_disabled;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (port_enable_ff[15:8] == 8'h00) [*2] |-> !grp_high_ff;
  endproperty
  a_grp_high_disabled: assert property (p_grp_high_disabled) else $error("disabled pins seen");

  property p_conv_rsvd;
    @(posedge I_MCLK) disable iff (!I_RST_N) conv_ser_ff[7:5] == 3'b000;
  endproperty
  a_conv_rsvd: assert property (p_conv_rsvd) else $error("reserved bits set");

  property p_dma_follow;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> dma_ser_ff[3:0] == $past(I_DMA_END_REQ);
  endproperty
  a_dma_follow: assert property (p_dma_follow) else $error("DMA flags lag");

  property p_conv_follow;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> conv_ser_ff[4] == $past(I_CONVERTER_DONE_REQ);
  endproperty
  a_conv_follow: assert property (p_conv_follow) else $error("converter flag lag");

  property p_ser_a;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> dma_ser_ff[7:4] == $past(I_SERIAL_A_REQ);
  endproperty
  a_ser_a: assert property (p_ser_a) else $error("serial A flags lag");

  property p_ser_b;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      1'b1 |=> conv_ser_ff[3:0] == $past(I_SERIAL_B_REQ);
  endproperty
  a_ser_b: assert property (p_ser_b) else $error("serial B flags lag");

  property p_ro_write;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      wr_acc && I_AVS_ADDRESS == irf_pkg::OFS_DMA_SER |=> dma_ser_ff[3:0] == $past(I_DMA_END_REQ);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only flags written");

  property p_write_one_keeps;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (wr_acc && I_AVS_ADDRESS == irf_pkg::OFS_EXT_FLAGS && I_AVS_WRITEDATA[0]
       && ext_flag[0] && ext_sense_ff[1:0] != irf_pkg::IRF_LOW) |=> ext_flag[0];
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag lost on 1");

  property p_clear_edge;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      ext_clr[0] && !ext_sense_ff[1] && $stable(ext_s2_ff[0]) |=> !ext_flag[0];
  endproperty
  a_clear_edge: assert property (p_clear_edge) else $error("edge flag not cleared");

  property p_fall_set;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      ext_sense_ff[1:0] == irf_pkg::IRF_FALLING && $fell(ext_s2_ff[0]) |=> ext_flag[0];
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("falling edge missed");

  property p_rise_set;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      ext_sense_ff[1:0] == irf_pkg::IRF_RISING && $rose(ext_s2_ff[0]) |=> ext_flag[0];
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rising edge missed");

  property p_level_follow;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      ext_sense_ff[1:0] == irf_pkg::IRF_LOW |=> ext_flag[0] == !$past(ext_s2_ff[0]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag not following");

  property p_rsvd_hold;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      ext_sense_ff[1:0] == irf_pkg::IRF_RSVD && !ext_clr[0] |=> $stable(ext_flag[0]);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved code changed flag");

  property p_irq_out;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      $rose(status_ff[0]) && mask_ff[0] |-> O_IRQ;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

  property p_wait_one;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (I_AVS_READ && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
endmodule
`default_nettype wire

// File: test/irf_src_model.sv
// Model of the peripheral request sources facing the flag block.
// Assumes the bench chooses the request levels and whether a source is slow.
`timescale 1ns/1ps
`default_nettype none
module irf_src_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [12:0] i_want,
  input wire logic i_slow,
  output logic [3:0] o_ser_a,
  output logic [3:0] o_dma,
  output logic o_conv,
  output logic [3:0] o_ser_b
);
  logic [12:0] stage_ff;
  logic [12:0] out_ff;
  // Requests stand as levels until withdrawn; a slow source answers one cycle later.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_ff <= 13'h0000;
      out_ff <= 13'h0000;
    end else begin
      stage_ff <= i_want;
      out_ff <= i_slow ? stage_ff : i_want;
    end
  end
  assign o_ser_a = out_ff[12:9];
  assign o_dma = out_ff[8:5];
  assign o_conv = out_ff[4];
  assign o_ser_b = out_ff[3:0];
endmodule
`default_nettype wire

// File: test/irf_top_tb.sv
// Self-checking bench for the interrupt request flag block.
// Assumes the block is the only slave on the bus and sources are modelled aside.
`timescale 1ns/1ps
`default_nettype none
module irf_top_tb;
  logic mclk, rst_n, avs_read, avs_write, avs_wait, irq, conv, slow;
  logic [5:0] avs_addr, ext_pin;
  logic [31:0] avs_wdata, avs_rdata, q;
  logic [15:0] port_pin, rnd, sense, en;
  logic [12:0] want, w;
  logic [3:0] ser_a, dma, ser_b, avs_be, be;
  int n_errors, checked;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  irf_top i_irf_top (.I_MCLK(mclk), .I_RST_N(rst_n), .I_AVS_ADDRESS(avs_addr),
    .I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_wdata),
    .I_AVS_BYTEENABLE(avs_be), .O_AVS_READDATA(avs_rdata), .O_AVS_WAITREQUEST(avs_wait),
    .I_EXTERNAL_REQUEST_PIN(ext_pin), .I_PORT_INTERRUPT_PIN(port_pin),
    .I_SERIAL_A_REQ(ser_a), .I_DMA_END_REQ(dma), .I_CONVERTER_DONE_REQ(conv),
    .I_SERIAL_B_REQ(ser_b), .O_IRQ(irq));
  irf_src_model i_irf_src_model (.i_clk(mclk), .i_rst_n(rst_n), .i_want(want),
    .i_slow(slow), .o_ser_a(ser_a), .o_dma(dma), .o_conv(conv), .o_ser_b(ser_b));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Group summaries: an enabled pin at its selected level raises its group.
  function automatic logic [7:0] grp(input logic [15:0] p, input logic [15:0] s,
      input logic [15:0] e);
    logic [15:0] hit;
    hit = e & ~(p ^ s);
    return {|hit[7:0], |hit[15:8], 6'h00};
  endfunction
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_addr <= a;
    avs_wdata <= d;
    avs_be <= be;
    @(posedge mclk);
    while (avs_wait !== 1'b0) @(posedge mclk);
    q = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(exp, q);
  endtask
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, slow} = 3'h0;
    {avs_addr, avs_wdata, want} = '0;
    {avs_be, be} = 8'hFF;
    ext_pin = 6'h3F;
    port_pin = 16'hFFFF;
    rnd = 16'h000B;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    rd(irf_pkg::OFS_DMA_SER, 32'h00000000);
    rd(irf_pkg::OFS_CONV_SER, 32'h00000000);
    rd(irf_pkg::OFS_EXT_SENSE, 32'h00000000);
    rd(irf_pkg::OFS_PORT_SENSE, 32'h00000000);
    rd(irf_pkg::OFS_PORT_ENABLE, 32'h00000000);
    rd(6'h20, irf_pkg::UNMAPPED_READ);
    $display("TEST reset values done");
    @(posedge mclk);
    ext_pin <= 6'h00;
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_FLAGS, 32'h0000003D);
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003D);
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000555);
    bus(1'b1, irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    @(posedge mclk);
    ext_pin <= 6'h3F;
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000AAA);
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    @(posedge mclk);
    ext_pin <= 6'h00;
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000FFF);
    @(posedge mclk);
    ext_pin <= 6'h3F;
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000000);
    bus(1'b1, irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    $display("TEST external lines done");
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      sense = (i < 2) ? 16'h0000 : rnd;
      rnd = lfsr(rnd);
      en = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hFFFF : rnd);
      rnd = lfsr(rnd);
      bus(1'b1, irf_pkg::OFS_PORT_SENSE, {16'h0000, sense});
      bus(1'b1, irf_pkg::OFS_PORT_ENABLE, {16'h0000, en});
      @(posedge mclk);
      port_pin <= (i == 1) ? 16'hFF00 : rnd;
      settle();
      rd(irf_pkg::OFS_EXT_FLAGS, {24'h000000, grp(port_pin, sense, en)});
    end
    bus(1'b1, irf_pkg::OFS_PORT_ENABLE, 32'h00000000);
    bus(1'b1, irf_pkg::OFS_PORT_SENSE, 32'h00000000);
    be = 4'h2;
    bus(1'b1, irf_pkg::OFS_PORT_SENSE, 32'h00001234);
    be = 4'h1;
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000F00);
    be = 4'hF;
    rd(irf_pkg::OFS_PORT_SENSE, 32'h00001200);
    rd(irf_pkg::OFS_EXT_SENSE, 32'h00000000);
    $display("TEST port groups done");
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      w = (i == 0) ? 13'h1FFF : ((i == 11) ? 13'h0000 : rnd[12:0]);
      @(posedge mclk);
      want <= w;
      slow <= rnd[15];
      settle();
      bus(1'b1, irf_pkg::OFS_DMA_SER, 32'h000000FF);
      bus(1'b1, irf_pkg::OFS_CONV_SER, 32'h0000001F);
      rd(irf_pkg::OFS_DMA_SER, {24'h000000, w[12:5]});
      rd(irf_pkg::OFS_CONV_SER, {27'h0000000, w[4:0]});
    end
    $display("TEST module requests done");
    bus(1'b1, irf_pkg::OFS_IRQ_STATUS, 32'h00000007);
    bus(1'b1, irf_pkg::OFS_IRQ_MASK, 32'h00000000);
    rd(irf_pkg::OFS_IRQ_STATUS, 32'h00000000);
    @(posedge mclk);
    want <= 13'h0020;
    settle();
    rd(irf_pkg::OFS_IRQ_STATUS, 32'h00000002);
    chk(32'h00000000, {31'h00000000, irq});
    bus(1'b1, irf_pkg::OFS_IRQ_MASK, 32'h00000002);
    @(negedge mclk);
    chk(32'h00000001, {31'h00000000, irq});
    want <= 13'h0000;
    settle();
    chk(32'h00000001, {31'h00000000, irq});
    bus(1'b1, irf_pkg::OFS_IRQ_STATUS, 32'h00000002);
    @(negedge mclk);
    chk(32'h00000000, {31'h00000000, irq});
    rd(irf_pkg::OFS_IRQ_STATUS, 32'h00000000);
    $display("TEST interrupt done");
    @(posedge mclk);
    ext_pin <= 6'h00;
    settle();
    ext_pin <= 6'h3F;
    settle();
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h0000003F);
    bus(1'b1, irf_pkg::OFS_EXT_SENSE, 32'h00000555);
    bus(1'b1, irf_pkg::OFS_IRQ_MASK, 32'h00000007);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(irf_pkg::OFS_EXT_FLAGS, 32'h00000000);
    rd(irf_pkg::OFS_EXT_SENSE, 32'h00000000);
    rd(irf_pkg::OFS_IRQ_MASK, 32'h00000000);
    $display("TEST second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
